// *** core/indirect_data_addressing.sv ***
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module indirect_data_addressing
    import ind_addr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PADDR_W-1:0]    paddr,
    input  wire logic [PRDATA_W-1:0]   pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [PRDATA_W-1:0]   prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Core side
    output logic      [BANK_W-1:0]     bank_select,
    output logic      [DATA_W-1:0]     working_value
);

    apb_state_t          state_r;
    logic                capture;
    logic                complete;
    logic                wr_ok;
    apb_state_t          state_nxt;
    logic                req_same;
    logic [PADDR_W-1:0]  req_addr_r;
    logic                req_write_r;

    // Address decode
    logic [NUM_PTR-1:0]  hit_low;
    logic [NUM_PTR-1:0]  hit_high;
    logic [NUM_PTR-1:0]  hit_alias;
    logic                hit_bank;
    logic                hit_work;
    logic                any_alias;
    logic                kind_ok;
    logic                aligned;
    logic                mapped;
    alias_t              kind;
    logic [2:0]          slot;

    // Read path
    logic [DATA_W-1:0]   rd_part [NUM_PTR];
    logic [MEM_AW-1:0]   addr_part [NUM_PTR];
    logic [DATA_W-1:0]   rd_byte;
    logic [MEM_AW-1:0]   mem_addr;
    logic [DATA_W-1:0]   prdata_r;
    logic                from_mem_r;
    logic                err_r;

    // Software registers
    logic [BANK_W-1:0]   bank_r;
    logic [DATA_W-1:0]   work_r;

    ptr_if               pif [NUM_PTR] ();
    mem_if               mif ();

    // Pointer bytes and the two software registers share the lowest
    // window; each pointer owns a window of eight alias slots, of
    // which the first five are live and the rest refuse the access.
    assign aligned   = (paddr[WORD_MSB:0] == WORD_ALIGN);
    assign slot      = paddr[KIND_MSB:KIND_LSB];

    // Slots above the offset alias are holes and are refused
    always_comb
    begin
        kind_ok = 1'b1;
        kind    = AL_PLAIN;
        unique case (slot)
            AL_PLAIN:   kind = AL_PLAIN;
            AL_POSTINC: kind = AL_POSTINC;
            AL_POSTDEC: kind = AL_POSTDEC;
            AL_PREINC:  kind = AL_PREINC;
            AL_WOFF:    kind = AL_WOFF;
            default:
            begin
                kind_ok = 1'b0;
                kind    = AL_PLAIN;
            end
        endcase
    end

    assign hit_bank  = (paddr == OFF_BANK);
    assign hit_work  = (paddr == OFF_WORK);
    assign any_alias = |hit_alias;
    assign mapped    = (|hit_low) | (|hit_high) | any_alias
                     | hit_bank | hit_work;

    // The request is taken into the capture stage first so that the
    // memory read data arrive from a register; as this falls in the setup
    // phase it costs no wait state, and it keeps all read data registered.
    assign capture  = clk_en & psel & (state_r == ST_IDLE);
    assign complete = clk_en & psel & penable & (state_r == ST_READY);
    // A master that moves the request after setup would pair data
    // fetched for one address with another; such an access is refused
    assign req_same = (paddr == req_addr_r) & (pwrite == req_write_r);
    assign wr_ok    = complete & req_same & pwrite & pstrb[0] & mapped;

    genvar g;
    generate
        for (g = 0; g < NUM_PTR; g++)
        begin : g_ptr
            logic in_window;

            assign in_window    = (paddr[REGION_MSB:REGION_LSB]
                                   == REGION_PTR[g]);
            assign hit_low[g]   = (paddr == OFF_PTR_LOW[g]);
            assign hit_high[g]  = (paddr == OFF_PTR_HIGH[g]);
            assign hit_alias[g] = aligned & kind_ok & in_window;

            assign pif[g].wr_low  = wr_ok & hit_low[g];
            assign pif[g].wr_high = wr_ok & hit_high[g];
            assign pif[g].wdata   = pwdata[DATA_W-1:0];
            assign pif[g].kind    = kind;
            assign pif[g].offset  = work_r;
            // Pointer moves at the completing edge, after the access
            assign pif[g].step    = complete & req_same & hit_alias[g];

            assign rd_part[g] =
                hit_low[g]  ? pif[g].low :
                hit_high[g] ? {{(DATA_W-PTR_HI_W){1'b0}}, pif[g].high} :
                              BYTE_ZERO;
            assign addr_part[g] = hit_alias[g] ? pif[g].addr
                                               : {MEM_AW{1'b0}};

            ptr_unit u_ptr (
                .pclk   (pclk),
                .clk_en (clk_en),
                .p      (pif[g])
            );
        end
    endgenerate

    // At most one pointer hits, so its part can be merged by a plain or
    always_comb
    begin
        mem_addr = {MEM_AW{1'b0}};
        for (int i = 0; i < NUM_PTR; i++)
        begin
            mem_addr = mem_addr | addr_part[i];
        end
    end

    always_comb
    begin
        rd_byte = BYTE_ZERO;
        for (int i = 0; i < NUM_PTR; i++)
        begin
            rd_byte = rd_byte | rd_part[i];
        end
        if (hit_bank)
        begin
            rd_byte = {{(DATA_W-BANK_W){1'b0}}, bank_r};
        end
        if (hit_work)
        begin
            rd_byte = work_r;
        end
    end

    // Alias traffic goes to data memory only; nothing is stored here
    assign mif.addr  = mem_addr;
    assign mif.wdata = pwdata[DATA_W-1:0];
    assign mif.we    = complete & req_same & pwrite & pstrb[0]
                     & any_alias;
    assign mif.re    = capture & ~pwrite & any_alias;

    data_mem u_mem (
        .pclk   (pclk),
        .clk_en (clk_en),
        .m      (mif)
    );

    // Both moves carry the clock enable, so a low enable holds the state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (capture)
                begin
                    state_nxt = ST_READY;
                end
            end
            ST_READY:
            begin
                if (complete)
                begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Request as taken at the capture edge; the access phase must
    // present the same address and direction to be honoured
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_addr_r  <= {PADDR_W{1'b0}};
            req_write_r <= 1'b0;
        end
        else if (capture)
        begin
            req_addr_r  <= paddr;
            req_write_r <= pwrite;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= BYTE_ZERO;
        end
        else if (capture)
        begin
            prdata_r <= rd_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            from_mem_r <= 1'b0;
        end
        else if (capture)
        begin
            from_mem_r <= any_alias;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_r <= 1'b0;
        end
        else if (capture)
        begin
            err_r <= ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bank_r <= BANK_RST;
        end
        else if (wr_ok && hit_bank)
        begin
            bank_r <= pwdata[BANK_W-1:0];
        end
    end

    // Working register is data, left unknown until loaded
    always_ff @(posedge pclk)
    begin
        if (wr_ok && hit_work)
        begin
            work_r <= pwdata[DATA_W-1:0];
        end
    end

    assign pready  = psel & penable & clk_en & (state_r == ST_READY);
    // Refused: unmapped at capture, or request moved since capture
    assign pslverr = pready & (err_r | ~req_same);
    assign prdata  = {{(PRDATA_W-DATA_W){1'b0}},
                      from_mem_r ? mif.rdata : prdata_r};

    assign bank_select   = bank_r;
    assign working_value = work_r;

endmodule : indirect_data_addressing

// *** core/ind_addr_pkg.sv ***
package ind_addr_pkg;

    // Widths
    localparam int MEM_AW    = 12;
    localparam int DATA_W    = 8;
    localparam int PTR_HI_W  = 4;
    localparam int BANK_W    = 4;
    localparam int PADDR_W   = 8;
    localparam int PRDATA_W  = 32;
    localparam int NUM_PTR   = 2;
    localparam int MEM_DEPTH = 4096;

    // Address field positions
    localparam int REGION_MSB = 7;
    localparam int REGION_LSB = 5;
    localparam int KIND_MSB   = 4;
    localparam int KIND_LSB   = 2;
    localparam int WORD_MSB   = 1;

    // Register byte addresses
    localparam logic [PADDR_W-1:0] OFF_PTR1_LOW  = 8'h00;
    localparam logic [PADDR_W-1:0] OFF_PTR1_HIGH = 8'h04;
    localparam logic [PADDR_W-1:0] OFF_PTR2_LOW  = 8'h08;
    localparam logic [PADDR_W-1:0] OFF_PTR2_HIGH = 8'h0C;
    localparam logic [PADDR_W-1:0] OFF_BANK      = 8'h10;
    localparam logic [PADDR_W-1:0] OFF_WORK      = 8'h14;

    // Alias windows, selected by the region field
    localparam logic [2:0] REGION_PTR1 = 3'h1;
    localparam logic [2:0] REGION_PTR2 = 3'h2;
    localparam logic [1:0] WORD_ALIGN  = 2'h0;

    localparam logic [PADDR_W-1:0] OFF_PTR_LOW  [NUM_PTR] =
        '{OFF_PTR1_LOW, OFF_PTR2_LOW};
    localparam logic [PADDR_W-1:0] OFF_PTR_HIGH [NUM_PTR] =
        '{OFF_PTR1_HIGH, OFF_PTR2_HIGH};
    localparam logic [2:0]         REGION_PTR   [NUM_PTR] =
        '{REGION_PTR1, REGION_PTR2};

    // Reset values and steps
    localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [MEM_AW-1:0] PTR_STEP = 12'h001;

    typedef enum logic [2:0] {
        AL_PLAIN   = 3'h0,
        AL_POSTINC = 3'h1,
        AL_POSTDEC = 3'h2,
        AL_PREINC  = 3'h3,
        AL_WOFF    = 3'h4
    } alias_t;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_READY = 1'b1
    } apb_state_t;

endpackage : ind_addr_pkg

// *** core/ind_links.sv ***
`timescale 1ns/1ps
interface ptr_if;
    import ind_addr_pkg::*;
    logic                  wr_low;
    logic                  wr_high;
    logic [DATA_W-1:0]     wdata;
    alias_t                kind;
    logic [DATA_W-1:0]     offset;
    logic                  step;
    logic [MEM_AW-1:0]     addr;
    logic [DATA_W-1:0]     low;
    logic [PTR_HI_W-1:0]   high;

    modport unit (input wr_low, wr_high, wdata, kind, offset, step,
                  output addr, low, high);
    modport ctrl (output wr_low, wr_high, wdata, kind, offset, step,
                  input addr, low, high);
endinterface : ptr_if

interface mem_if;
    import ind_addr_pkg::*;
    logic                  we;
    logic                  re;
    logic [MEM_AW-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;

    modport mem  (input we, re, addr, wdata, output rdata);
    modport ctrl (output we, re, addr, wdata, input rdata);
endinterface : mem_if

// *** core/data_mem.sv ***
`timescale 1ns/1ps
module data_mem
    import ind_addr_pkg::*;
(
    // Clock
    input  wire logic  pclk,
    input  wire logic  clk_en,
    // Access port
    mem_if.mem         m
);

    logic [DATA_W-1:0] store_r [MEM_DEPTH];
    logic [DATA_W-1:0] rdata_r;

    // Contents are not reset: data memory powers up unknown
    always_ff @(posedge pclk)
    begin
        if (clk_en && m.we)
        begin
            store_r[m.addr] <= m.wdata;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (clk_en && m.re)
        begin
            rdata_r <= store_r[m.addr];
        end
    end

    assign m.rdata = rdata_r;

endmodule : data_mem

// *** core/ptr_unit.sv ***
`timescale 1ns/1ps
module ptr_unit
    import ind_addr_pkg::*;
(
    // Clock
    input  wire logic  pclk,
    input  wire logic  clk_en,
    // Control side
    ptr_if.unit        p
);

    logic [DATA_W-1:0]   low_r;
    logic [PTR_HI_W-1:0] high_r;
    logic [MEM_AW-1:0]   ptr_q;
    logic [MEM_AW-1:0]   ptr_nxt;
    logic [MEM_AW-1:0]   offset_ext;

    assign ptr_q      = {high_r, low_r};
    // Working offset is signed, so an alias can reach below the pointer
    assign offset_ext = {{(MEM_AW-DATA_W){p.offset[DATA_W-1]}}, p.offset};

    always_comb
    begin
        ptr_nxt = ptr_q;
        unique case (p.kind)
            AL_POSTINC: ptr_nxt = ptr_q + PTR_STEP;
            AL_POSTDEC: ptr_nxt = ptr_q - PTR_STEP;
            AL_PREINC:  ptr_nxt = ptr_q + PTR_STEP;
            AL_PLAIN:   ptr_nxt = ptr_q;
            default:    ptr_nxt = ptr_q;
        endcase
    end

    always_comb
    begin
        p.addr = ptr_q;
        unique case (p.kind)
            AL_PLAIN:   p.addr = ptr_q;
            AL_POSTINC: p.addr = ptr_q;
            AL_POSTDEC: p.addr = ptr_q;
            AL_PREINC:  p.addr = ptr_q + PTR_STEP;
            AL_WOFF:    p.addr = ptr_q + offset_ext;
            default:    p.addr = ptr_q;
        endcase
    end

    // No reset on purpose: pointer bytes are undefined until software
    // loads them. A step and a byte write never come in the same cycle.
    always_ff @(posedge pclk)
    begin
        if (clk_en)
        begin
            if (p.step)
            begin
                low_r  <= ptr_nxt[DATA_W-1:0];
                high_r <= ptr_nxt[MEM_AW-1:DATA_W];
            end
            else
            begin
                if (p.wr_low)
                begin
                    low_r <= p.wdata;
                end
                if (p.wr_high)
                begin
                    high_r <= p.wdata[PTR_HI_W-1:0];
                end
            end
        end
    end

    assign p.low  = low_r;
    assign p.high = high_r;

endmodule : ptr_unit

// *** bench/ind_chk.sv ***
`timescale 1ns/1ps
module ind_chk
    import ind_addr_pkg::*;
(
    // Clock, reset, enable
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                clk_en,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [PADDR_W-1:0]  paddr,
    input wire logic [PRDATA_W-1:0] pwdata,
    input wire logic [3:0]          pstrb,
    input wire logic [PRDATA_W-1:0] prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Core side
    input wire logic [BANK_W-1:0]   bank_select,
    input wire logic [DATA_W-1:0]   working_value
);
    logic in_alias;
    logic rd_done;
    logic wr_done;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign in_alias = paddr[REGION_MSB:REGION_LSB] == REGION_PTR1
                   || paddr[REGION_MSB:REGION_LSB] == REGION_PTR2;
    assign rd_done  = pready && !pwrite;
    assign wr_done  = pready && pwrite && pstrb[0];

    a_ready_in_access: assert property (pready |-> psel && penable && clk_en)
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_ready_no_wait: assert property (psel && !penable && clk_en
        ##1 psel && penable && clk_en |-> pready)
        else $error("access phase not answered at once");
    a_upper_read_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_high_narrow: assert property (
        rd_done && paddr == OFF_PTR1_HIGH |-> prdata[31:4] == 28'h0)
        else $error("pointer high byte reads wide");
    a_bank_write: assert property (wr_done && paddr == OFF_BANK
        |=> bank_select == $past(pwdata[3:0]))
        else $error("bank select not written");
    a_work_write: assert property (wr_done && paddr == OFF_WORK
        |=> working_value == $past(pwdata[7:0]))
        else $error("working register not written");
    a_alias_no_store: assert property (
        pready && pwrite && in_alias
        |=> $stable(working_value) && $stable(bank_select))
        else $error("alias write landed in a register");
    a_alias_unmapped: assert property (pready && in_alias
        && paddr[KIND_MSB:KIND_LSB] > 3'h4 |-> pslverr)
        else $error("unmapped alias slot not refused");
endmodule : ind_chk

bind indirect_data_addressing ind_chk ind_chk_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bank_select(bank_select), .working_value(working_value));

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import ind_addr_pkg::*;
    logic                pclk, presetn, clk_en, psel, penable, pwrite;
    logic                pready, pslverr, erv;
    logic [PADDR_W-1:0]  paddr;
    logic [PRDATA_W-1:0] pwdata, prdata, rdv;
    logic [3:0]          pstrb;
    logic [BANK_W-1:0]   bank_select;
    logic [DATA_W-1:0]   working_value;
    int                  failures, samples_checked, waits;

    indirect_data_addressing dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bank_select(bank_select), .working_value(working_value));

    always #2.5 pclk = ~pclk;

    task report_and_stop;
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask : chk

    // Pready and read data are taken at the rising edge itself: the
    // design's flops only launch new values after that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        waits = n;
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic [7:0] ali(input int i, input int k);
        return {REGION_PTR[i], k[2:0], WORD_ALIGN};
    endfunction : ali

    task setp(input int i, input logic [11:0] v);
        wr(OFF_PTR_LOW[i], {24'h0, v[7:0]});
        wr(OFF_PTR_HIGH[i], {28'h0, v[11:8]});
    endtask : setp

    task ptr_is(input int i, input logic [11:0] v);
        rd(OFF_PTR_LOW[i]);
        chk("pointer low", {24'h0, v[7:0]}, rdv);
        rd(OFF_PTR_HIGH[i]);
        chk("pointer high", {28'h0, v[11:8]}, rdv);
    endtask : ptr_is

    task t_bank;
        rd(OFF_BANK);
        chk("bank reset", 32'h0, rdv);
        wr(OFF_BANK, 32'hFF);
        rd(OFF_BANK);
        chk("bank read", 32'h0F, rdv);
        chk("bank port", 32'h0F, {28'h0, bank_select});
    endtask : t_bank

    task t_plain_post;
        setp(0, 12'h123);
        wr(ali(0, 0), 32'hA5);
        ptr_is(0, 12'h123);
        rd(ali(0, 1));
        chk("postinc data", 32'hA5, rdv);
        ptr_is(0, 12'h124);
    endtask : t_plain_post

    task t_postdec;
        setp(1, 12'h200);
        wr(ali(1, 2), 32'h11);
        wr(ali(1, 2), 32'h22);
        ptr_is(1, 12'h1FE);
        setp(1, 12'h1FF);
        rd(ali(1, 0));
        chk("postdec second", 32'h22, rdv);
        setp(1, 12'h200);
        rd(ali(1, 0));
        chk("postdec first", 32'h11, rdv);
    endtask : t_postdec

    task t_pre_and_offset;
        setp(0, 12'h0FF);
        wr(ali(0, 3), 32'h33);
        ptr_is(0, 12'h100);
        rd(ali(0, 0));
        chk("preinc data", 32'h33, rdv);
        wr(OFF_WORK, 32'h02);
        setp(1, 12'h0FE);
        rd(ali(1, 4));
        chk("offset plus", 32'h33, rdv);
        ptr_is(1, 12'h0FE);
        wr(OFF_WORK, 32'hFF);
        setp(1, 12'h101);
        rd(ali(1, 4));
        chk("offset minus", 32'h33, rdv);
    endtask : t_pre_and_offset

    // Enable low over the setup edge delays the capture until it rises
    task t_freeze;
        setp(0, 12'h300);
        clk_en <= 1'b0;
        fork
            wr(ali(0, 1), 32'h5A);
            begin
                repeat (3) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        chk("frozen waits", 32'd3, waits);
        ptr_is(0, 12'h301);
        setp(0, 12'h300);
        rd(ali(0, 0));
        chk("frozen data", 32'h5A, rdv);
    endtask : t_freeze

    // A cleared byte strobe stores nothing, yet an alias still steps
    task t_strobe;
        setp(1, 12'h400);
        wr(ali(1, 0), 32'h66);
        wr(OFF_WORK, 32'h44);
        pstrb <= 4'hE;
        wr(OFF_WORK, 32'h77);
        wr(ali(1, 1), 32'h99);
        pstrb <= 4'hF;
        rd(OFF_WORK);
        chk("masked work", 32'h44, rdv);
        ptr_is(1, 12'h401);
        setp(1, 12'h400);
        rd(ali(1, 0));
        chk("masked alias", 32'h66, rdv);
    endtask : t_strobe

    task t_unmapped;
        rd(ali(0, 5));
        chk("alias gap err", 32'h1, {31'h0, erv});
        chk("alias gap data", 32'h0, rdv);
        wr(ali(1, 7), 32'h55);
        chk("alias gap werr", 32'h1, {31'h0, erv});
    endtask : t_unmapped

    initial
    begin
        pclk = 0;
        presetn = 0;
        clk_en = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_bank;
        t_plain_post;
        t_postdec;
        t_pre_and_offset;
        t_freeze;
        t_strobe;
        t_unmapped;
        report_and_stop;
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        failures++;
        report_and_stop;
    end
endmodule : tb_top
